// >>> aotf_regs.svh
// Register offsets, field positions, reset values and counts of the output test and format block
`ifndef AOTF_REGS_SVH
`define AOTF_REGS_SVH

`define AOTF_ADDR_PERF 8'h03
`define AOTF_ADDR_GAIN_PAT 8'h25
`define AOTF_ADDR_CODING 8'h29
`define AOTF_ADDR_CUST_HI 8'h3f
`define AOTF_ADDR_CUST_LO 8'h40

`define AOTF_RST_PERF 8'h00
`define AOTF_RST_GAIN_PAT 8'h00
`define AOTF_RST_CODING 8'h00
`define AOTF_RST_CUST_HI 8'h00
`define AOTF_RST_CUST_LO 8'h00

`define AOTF_GAIN_MSB 7
`define AOTF_GAIN_LSB 4
`define AOTF_PAT_MSB 2
`define AOTF_PAT_LSB 0
`define AOTF_CODING_MSB 4
`define AOTF_CODING_LSB 3
`define AOTF_PERF_MSB 1
`define AOTF_PERF_LSB 0
`define AOTF_CUST_HI_MSB 5
`define AOTF_CODING_OFFSET_BIN 2'h3

`define AOTF_SER_BITS 16
`define AOTF_RAMP_DIV_NARROW 4
`define AOTF_FIFO_DEPTH 8

`endif

// >>> aotf_pkg.sv
// Types shared by the output test and format block
package aotf_pkg;
    typedef enum logic [2:0]
    {
        AOTF_PAT_NORMAL = 3'b000,
        AOTF_PAT_ZEROS = 3'b001,
        AOTF_PAT_ONES = 3'b010,
        AOTF_PAT_TOGGLE = 3'b011,
        AOTF_PAT_RAMP = 3'b100,
        AOTF_PAT_CUSTOM = 3'b101,
        AOTF_PAT_UNUSED6 = 3'b110,
        AOTF_PAT_UNUSED7 = 3'b111
    } aotf_pattern_e;

    typedef logic [3:0] aotf_gain_t;
    typedef logic [1:0] aotf_coding_t;
endpackage

// >>> aotf_stream_if.sv
// Valid/ready word stream between the output path and its FIFO
`timescale 1ns/1ps
interface aotf_stream_if #(parameter int WIDTH = 14);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// >>> aotf_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module aotf_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    aotf_stream_if.sink in_s,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("aotf_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;

    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = in_s.valid && !full;
    wire pop = !empty && out_ready;

    assign in_s.ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_q[AW-1:0]] <= in_s.data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule

// >>> aotf_output_ctrl.sv
// Serial-configured test pattern, gain and output coding control of one converter channel
//
// Summary of operation
// - Gain code n means n half-dB; reset 0000
// - Pattern field bits 2:0 selects output source
// - Toggle alternates 1010... and 0101... each sample
// - Ramp steps one LSB; narrow variant every fourth
// - Coding 11 offset binary, else twos complement
// - Pattern codes 000 to 101; 110, 111 unused
// - Custom word from two registers; narrow uses upper
`timescale 1ns/1ps
`include "aotf_regs.svh"
module aotf_output_ctrl #(
    parameter int DATA_W = 14,
    parameter int FIFO_DEPTH = `AOTF_FIFO_DEPTH
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic SEN_N,
    input wire logic SCLK,
    input wire logic SDATA,
    input wire logic READOUT_EN,
    output logic SDOUT_O,
    output logic SDOUT_OE,
    input wire logic ADC_VALID,
    output logic ADC_READY,
    input wire logic [DATA_W-1:0] ADC_DATA,
    output logic DOUT_VALID,
    input wire logic DOUT_READY,
    output logic [DATA_W-1:0] DOUT,
    output aotf_pkg::aotf_gain_t CHA_GAIN_CODE,
    output aotf_pkg::aotf_pattern_e CHA_PATTERN_SELECT,
    output aotf_pkg::aotf_coding_t OUTPUT_CODING,
    output logic [1:0] PERF_TUNING_SELECT
);
    import aotf_pkg::*;

    initial
    begin
        if (DATA_W != 14 && DATA_W != 12)
            $error("aotf_output_ctrl: DATA_W must be 14 or 12");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [2:0] sen_meta_q;
    logic [2:0] sen_sync_q;
    logic sclk_last_q;

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            sen_meta_q <= 3'b101;
            sen_sync_q <= 3'b101;
            sclk_last_q <= 1'b0;
        end
        else
        begin
            sen_meta_q <= {SEN_N, SCLK, SDATA};
            sen_sync_q <= sen_meta_q;
            sclk_last_q <= sen_sync_q[1];
        end
    end

    wire sen_n_s = sen_sync_q[2];
    wire sclk_s = sen_sync_q[1];
    wire sdata_s = sen_sync_q[0];
    wire sclk_rise = sclk_s && !sclk_last_q && !sen_n_s;
    wire sclk_fall = !sclk_s && sclk_last_q && !sen_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame: eight address bits then eight data bits, first bit first

    logic [4:0] bit_cnt_q;
    logic [14:0] shift_q;
    logic [7:0] rd_shift_q;

    wire [15:0] frame = {shift_q, sdata_s};
    wire frame_done = sclk_rise && (bit_cnt_q == 5'(`AOTF_SER_BITS - 1));
    wire [7:0] frame_addr = frame[15:8];
    wire [7:0] frame_wdata = frame[7:0];
    wire addr_done = sclk_rise && (bit_cnt_q == 5'd7);

    logic [7:0] gain_pat_q;
    logic [7:0] coding_q;
    logic [7:0] perf_q;
    logic [5:0] cust_hi_q;
    logic [7:0] cust_lo_q;

    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        case (addr)
            `AOTF_ADDR_GAIN_PAT: reg_read = gain_pat_q;
            `AOTF_ADDR_CODING: reg_read = coding_q;
            `AOTF_ADDR_PERF: reg_read = perf_q;
            `AOTF_ADDR_CUST_HI: reg_read = {2'h0, cust_hi_q};
            `AOTF_ADDR_CUST_LO: reg_read = cust_lo_q;
            default: reg_read = 8'h00;
        endcase
    endfunction

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            bit_cnt_q <= 5'h00;
            shift_q <= 15'h0000;
            rd_shift_q <= 8'h00;
        end
        else if (sen_n_s)
        begin
            bit_cnt_q <= 5'h00;
        end
        else
        begin
            if (sclk_rise)
            begin
                shift_q <= frame[14:0];
                bit_cnt_q <= frame_done ? 5'h00 : bit_cnt_q + 5'h01;
            end
            if (addr_done)
                rd_shift_q <= reg_read({shift_q[6:0], sdata_s});
            else if (sclk_fall && bit_cnt_q > 5'd8)
                rd_shift_q <= {rd_shift_q[6:0], 1'b0};
        end
    end

    wire data_phase = !sen_n_s && (bit_cnt_q >= 5'd8);
    assign SDOUT_OE = READOUT_EN && data_phase;
    assign SDOUT_O = SDOUT_OE ? rd_shift_q[7] : 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Register bank

    wire wr_gain_pat = frame_done && (frame_addr == `AOTF_ADDR_GAIN_PAT);
    wire wr_coding = frame_done && (frame_addr == `AOTF_ADDR_CODING);
    wire wr_perf = frame_done && (frame_addr == `AOTF_ADDR_PERF);
    wire wr_cust_hi = frame_done && (frame_addr == `AOTF_ADDR_CUST_HI);
    wire wr_cust_lo = frame_done && (frame_addr == `AOTF_ADDR_CUST_LO);

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            gain_pat_q <= `AOTF_RST_GAIN_PAT;
            coding_q <= `AOTF_RST_CODING;
            perf_q <= `AOTF_RST_PERF;
            cust_hi_q <= 6'(`AOTF_RST_CUST_HI);
            cust_lo_q <= `AOTF_RST_CUST_LO;
        end
        else
        begin
            if (wr_gain_pat)
                gain_pat_q <= frame_wdata;
            if (wr_coding)
                coding_q <= frame_wdata;
            if (wr_perf)
                perf_q <= frame_wdata;
            if (wr_cust_hi)
                cust_hi_q <= frame_wdata[`AOTF_CUST_HI_MSB:0];
            if (wr_cust_lo)
                cust_lo_q <= frame_wdata;
        end
    end

    // Gain code is passed as is; each step is half a dB
    assign CHA_GAIN_CODE = gain_pat_q[`AOTF_GAIN_MSB:`AOTF_GAIN_LSB];
    assign CHA_PATTERN_SELECT = aotf_pattern_e'(gain_pat_q[`AOTF_PAT_MSB:`AOTF_PAT_LSB]);
    assign OUTPUT_CODING = coding_q[`AOTF_CODING_MSB:`AOTF_CODING_LSB];
    // Field stored as written; the host keeps it at 11
    assign PERF_TUNING_SELECT = perf_q[`AOTF_PERF_MSB:`AOTF_PERF_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // Pattern generator, advanced once per accepted sample

    aotf_stream_if #(.WIDTH(DATA_W)) gen_s ();

    wire take = ADC_VALID && gen_s.ready;
    logic toggle_q;
    logic [DATA_W-1:0] ramp_q;
    logic [1:0] ramp_div_q;

    localparam int RAMP_DIV = (DATA_W == 12) ? `AOTF_RAMP_DIV_NARROW : 1;
    wire ramp_step = (ramp_div_q == 2'(RAMP_DIV - 1));

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            toggle_q <= 1'b0;
            ramp_q <= '0;
            ramp_div_q <= 2'h0;
        end
        else if (take)
        begin
            toggle_q <= !toggle_q;
            ramp_div_q <= ramp_step ? 2'h0 : ramp_div_q + 2'h1;
            if (ramp_step)
                ramp_q <= ramp_q + 1'b1;
        end
    end

    function automatic logic [DATA_W-1:0] alt_word(input logic phase);
        logic [DATA_W-1:0] w;
        w = '0;
        for (int i = 0; i < DATA_W; i++)
            w[i] = phase ^ i[0];
        alt_word = w;
    endfunction

    wire [13:0] cust_word = {cust_hi_q, cust_lo_q};
    wire [DATA_W-1:0] cust_out = cust_word[13 -: DATA_W];
    wire offset_bin = (OUTPUT_CODING == `AOTF_CODING_OFFSET_BIN);
    wire [DATA_W-1:0] coded = {ADC_DATA[DATA_W-1] ^ offset_bin, ADC_DATA[DATA_W-2:0]};

    logic [DATA_W-1:0] gen_word;
    always_comb
    begin
        unique case (CHA_PATTERN_SELECT)
            AOTF_PAT_NORMAL: gen_word = coded;
            AOTF_PAT_ZEROS: gen_word = '0;
            AOTF_PAT_ONES: gen_word = '1;
            AOTF_PAT_TOGGLE: gen_word = alt_word(!toggle_q);
            AOTF_PAT_RAMP: gen_word = ramp_q;
            AOTF_PAT_CUSTOM: gen_word = cust_out;
            AOTF_PAT_UNUSED6: gen_word = coded;
            AOTF_PAT_UNUSED7: gen_word = coded;
        endcase
    end

    // Generated word takes the sample's place in the same handshake slot
    assign gen_s.valid = ADC_VALID;
    assign gen_s.data = gen_word;
    assign ADC_READY = gen_s.ready;

    aotf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CORE_CLK),
        .rst(RESET),
        .in_s(gen_s),
        .out_valid(DOUT_VALID),
        .out_ready(DOUT_READY),
        .out_data(DOUT)
    );
endmodule

// >>> aotf_output_ctrl_assertions.sv
// Assertions on the ports of the output test and format block
`timescale 1ns/1ps
module aotf_chk #(parameter int DATA_W = 14)
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic ADC_VALID,
    input wire logic ADC_READY,
    input wire logic [DATA_W-1:0] ADC_DATA,
    input wire logic DOUT_VALID,
    input wire logic DOUT_READY,
    input wire logic [DATA_W-1:0] DOUT,
    input wire aotf_pkg::aotf_gain_t CHA_GAIN_CODE,
    input wire aotf_pkg::aotf_pattern_e CHA_PATTERN_SELECT,
    input wire aotf_pkg::aotf_coding_t OUTPUT_CODING
);
    import aotf_pkg::*;
    localparam logic [DATA_W-1:0] MSB = {1'b1, {(DATA_W-1){1'b0}}};
    wire logic take0 = ADC_VALID && ADC_READY && !DOUT_VALID;
    wire logic norm = CHA_PATTERN_SELECT == AOTF_PAT_NORMAL;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////
    a_reset_clear: assert property ($fell(RESET) |->
        !DOUT_VALID && CHA_GAIN_CODE == 4'h0 && OUTPUT_CODING == 2'h0) else $error("reset state");
    a_stall_hold: assert property (DOUT_VALID && !DOUT_READY |=>
        DOUT_VALID && $stable(DOUT)) else $error("word dropped");
    a_empty_ready: assert property (!DOUT_VALID |-> ADC_READY) else $error("refused");
    a_first_word: assert property (take0 |=> DOUT_VALID) else $error("late word");
    a_zero_word: assert property (take0 && CHA_PATTERN_SELECT == AOTF_PAT_ZEROS |=>
        DOUT == '0) else $error("zeros");
    a_ones_word: assert property (take0 && CHA_PATTERN_SELECT == AOTF_PAT_ONES |=>
        DOUT == '1) else $error("ones");
    a_offset_bin: assert property (take0 && norm && OUTPUT_CODING == 2'h3 |=>
        DOUT == ($past(ADC_DATA) ^ MSB)) else $error("offset binary");
    a_twos_comp: assert property (take0 && norm && OUTPUT_CODING != 2'h3 |=>
        DOUT == $past(ADC_DATA)) else $error("twos complement");
endmodule
bind aotf_output_ctrl aotf_chk #(.DATA_W(DATA_W)) u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .ADC_VALID(ADC_VALID), .ADC_READY(ADC_READY), .ADC_DATA(ADC_DATA), .DOUT_VALID(DOUT_VALID),
    .DOUT_READY(DOUT_READY), .DOUT(DOUT), .CHA_GAIN_CODE(CHA_GAIN_CODE),
    .CHA_PATTERN_SELECT(CHA_PATTERN_SELECT), .OUTPUT_CODING(OUTPUT_CODING));

// >>> aotf_capture.sv
// Downstream capture logic that takes words with random stalls
`timescale 1ns/1ps
module aotf_capture #(parameter int DATA_W = 14)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic valid,
    input wire logic [DATA_W-1:0] data,
    output logic ready
);
    int seed = 811;
    int n_words = 0;
    logic [DATA_W-1:0] last_q;
    initial ready = 1'b0;
    always @(posedge clk)
    begin
        if (valid && ready)
        begin
            n_words <= n_words + 1;
            last_q <= data;
        end
        ready <= !rst && !stall && ($random(seed) % 4 != 0);
    end
endmodule

// >>> tb_top.sv
// Self-checking bench of the output test and format block
`timescale 1ns/1ps
`include "aotf_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
    import aotf_pkg::*;
    logic core_clk = 0;
    logic reset = 1;
    logic sen_n = 1, sclk = 0, sdata = 0, readout_en = 0, adc_valid = 0, stall = 0;
    logic [13:0] adc_data = '0;
    logic adc_ready, dout_valid, dout_ready, sdout_o, sdout_oe;
    logic [13:0] dout;
    aotf_gain_t gain;
    aotf_pattern_e pat_o;
    aotf_coding_t cod_o;
    logic [1:0] perf;
    int failures = 0, n_compared = 0, seed = 47427, n_acc = 0, cnt;
    logic [2:0] pat = 0;
    logic [1:0] cod = 0;
    logic [13:0] cust;
    logic [13:0] exp_q[$];
    logic [13:0] exp_w;
    logic [7:0] rd;
    aotf_output_ctrl #(.DATA_W(14)) dut (.CORE_CLK(core_clk), .RESET(reset), .SEN_N(sen_n), .SCLK(sclk),
        .SDATA(sdata), .READOUT_EN(readout_en), .SDOUT_O(sdout_o), .SDOUT_OE(sdout_oe), .ADC_VALID(adc_valid),
        .ADC_READY(adc_ready), .ADC_DATA(adc_data), .DOUT_VALID(dout_valid), .DOUT_READY(dout_ready),
        .DOUT(dout), .CHA_GAIN_CODE(gain), .CHA_PATTERN_SELECT(pat_o), .OUTPUT_CODING(cod_o),
        .PERF_TUNING_SELECT(perf));
    aotf_capture #(.DATA_W(14)) cap (.clk(core_clk), .rst(reset), .stall(stall), .valid(dout_valid),
        .data(dout), .ready(dout_ready));
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) adc_data <= $random(seed);
    ////////////////////////////////////////////////////////////////
    function automatic logic [13:0] expw(logic [13:0] a);
        case (pat)
            3'h1: return 14'h0000;
            3'h2: return 14'h3fff;
            3'h3: return n_acc[0] ? 14'h2aaa : 14'h1555;
            3'h4: return n_acc[13:0];
            3'h5: return cust;
            default: return (cod == 2'h3) ? (a ^ 14'h2000) : a;
        endcase
    endfunction
    // Judged at the falling edge, where every port has settled
    always @(negedge core_clk)
    begin
        if (!reset && dout_valid && dout_ready)
        begin
            exp_w = exp_q.pop_front();
            `CHK(dout, exp_w)
        end
        if (!reset && adc_valid && adc_ready)
        begin
            exp_q.push_back(expw(adc_data));
            n_acc++;
        end
    end
    task automatic xfer(input logic [7:0] addr, input logic [7:0] data);
        logic [15:0] w;
        w = {addr, data};
        sen_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        for (int i = 15; i >= 0; i--)
        begin
            sdata <= w[i];
            repeat (5) @(posedge core_clk);
            @(negedge core_clk);
            rd[i % 8] = sdout_o;
            `CHK(sdout_oe, readout_en && (i < 8))
            @(posedge core_clk);
            sclk <= 1'b1;
            repeat (6) @(posedge core_clk);
            sclk <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
        sen_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic drain();
        for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge core_clk);
        `CHK(exp_q.size(), 0)
        if (exp_q.size() > 0)
            report_and_stop();
        repeat (2) @(posedge core_clk);
        `CHK(cap.n_words, n_acc)
        `CHK(cap.last_q, exp_w)
    endtask
    task automatic report_and_stop();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK({gain, pat_o, cod_o, perf}, 11'h000)
        xfer(`AOTF_ADDR_PERF, 8'h03);
        `CHK(perf, 2'h3)
        cust = $random(seed);
        xfer(`AOTF_ADDR_CUST_HI, {2'b00, cust[13:8]});
        xfer(`AOTF_ADDR_CUST_LO, cust[7:0]);
        readout_en <= 1'b1;
        xfer(8'h55, 8'h00);
        `CHK(rd, 8'h00)
        // Sink stalled: exactly the FIFO depth is taken, then refused
        stall <= 1'b1;
        repeat (2) @(posedge core_clk);
        cnt = n_acc;
        adc_valid <= 1'b1;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(n_acc - cnt, 8)
        `CHK(adc_ready, 1'b0)
        @(posedge core_clk);
        adc_valid <= 1'b0;
        stall <= 1'b0;
        drain();
        for (int k = 0; k < 8; k++)
        begin
            pat = k[2:0];
            cod = k[1:0] + 2'h3;
            xfer(`AOTF_ADDR_GAIN_PAT, {k[3:0] + 4'h5, 1'b0, pat});
            xfer(`AOTF_ADDR_CODING, {3'b000, cod, 3'b000});
            `CHK(gain, k[3:0] + 4'h5)
            `CHK({pat_o, cod_o}, {pat, cod})
            xfer(`AOTF_ADDR_GAIN_PAT, {k[3:0] + 4'h5, 1'b0, pat});
            `CHK(rd, {k[3:0] + 4'h5, 1'b0, pat})
            repeat (60)
            begin
                @(posedge core_clk);
                adc_valid <= $random(seed);
            end
            @(posedge core_clk);
            adc_valid <= 1'b0;
            drain();
        end
        report_and_stop();
    end
endmodule
